// >>> logic/pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second, idle level is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '1;
      sync_out   <= '1;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// >>> logic/port_pins_if.sv
// Pin-level meeting point of the device end and the external master end
`timescale 1ns/1ps
interface port_pins_if;

  // ==========================================================================
  // Driver halves of the three control pins and the eight data pins
  logic [2:0] dev_ctl_o;
  logic [2:0] dev_ctl_oe;
  logic [2:0] host_ctl_o;
  logic [2:0] host_ctl_oe;
  logic [7:0] dev_data_o;
  logic       dev_data_oe;
  logic [7:0] host_data_o;
  logic       host_data_oe;
  logic [2:0] ctl_level;
  logic [7:0] data_level;

  // Wire resolution, undriven pins rest high through pull-ups
  assign ctl_level  = (dev_ctl_oe & dev_ctl_o) | (~dev_ctl_oe & host_ctl_oe & host_ctl_o)
                    | (~dev_ctl_oe & ~host_ctl_oe);
  assign data_level = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hff);

  modport device (output dev_ctl_o, output dev_ctl_oe, output dev_data_o, output dev_data_oe,
                  input ctl_level, input data_level);
  modport host   (output host_ctl_o, output host_ctl_oe, output host_data_o, output host_data_oe,
                  input ctl_level, input data_level);

endinterface

// >>> logic/slave_port_device.sv
// Device end: control-pin port, direction/status register and parallel slave port
// Summary of operation
// [RQ1] Each control pin has its own direction
// [RQ2] Slave mode turns pins into strobe inputs
// [RQ3] Software sets direction bits when enabling mode
// [RQ4] Bit 7 reads one while input word waits
// [RQ5] Bit 6 reads one while output word waits
// [RQ6] Bit 5 flags overflow, cleared by writing zero
// [RQ7] Bit 4 selects slave mode, read/write
// [RQ8] Bit 3 always reads zero
// [RQ9] Bits 2..0 set select, write, read directions
// [RQ10] Reset value has direction bits set only
// [RQ11] Pin latch has three bits, not reset
// [RQ12] Low read strobe presents output latch
// [RQ13] Low write strobe captures bus into input latch
// [RQ14] Low select enables, high ignores strobes
// [RQ15] Port read gives pins, write sets latch
// [RQ16] Bit operations rewrite whole latch from pins
// [RQ17] Master never drives a driven pin
// [RQ18] CPU read of input latch clears full flag
// [RQ19] External read clears output full flag
// [RQ20] Mode off forces both full flags clear
// [RQ21] Each transfer sets sticky event flag
// [RQ22] Strobes synchronised, rising edge detected once
// [RQ23] Data pins driven only while selected and reading
`timescale 1ns/1ps
module slave_port_device #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  port_pins_if.device            pins
);

  // ==========================================================================
  // Register state
  logic [2:0] pin_latch_reg;
  logic [2:0] dir_reg;
  logic       slave_mode_reg;
  logic       input_full_reg;
  logic       output_full_reg;
  logic       overflow_reg;
  logic       slave_int_reg;
  logic [7:0] out_latch_reg;
  logic [7:0] in_latch_reg;

  // ==========================================================================
  // Pin synchronisation and strobe edge detection
  logic [10:0] pin_sync_q;
  logic [2:0]  ctl_sync;
  logic [7:0]  data_sync;
  logic        rd_prev_reg, wr_prev_reg, sel_prev_reg;
  logic        ext_read_done, ext_write_done;

  pin_sync #(
    .WIDTH (11)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pins.data_level, pins.ctl_level}),
    .sync_out (pin_sync_q)
  );

  assign ctl_sync  = pin_sync_q[2:0];
  assign data_sync = pin_sync_q[10:3];

  // Previous strobe levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_prev_reg  <= 1'b1;
      wr_prev_reg  <= 1'b1;
      sel_prev_reg <= 1'b1;
    end else begin
      rd_prev_reg  <= ctl_sync[slave_port_pkg::RD_PIN];
      wr_prev_reg  <= ctl_sync[slave_port_pkg::WR_PIN];
      sel_prev_reg <= ctl_sync[slave_port_pkg::SEL_PIN];
    end
  end

  // Transfer ends on the strobe rising edge while selected
  assign ext_read_done  = slave_mode_reg & ~sel_prev_reg & ~rd_prev_reg
                        & ctl_sync[slave_port_pkg::RD_PIN];                    // [RQ14] [RQ22]
  assign ext_write_done = slave_mode_reg & ~sel_prev_reg & ~wr_prev_reg
                        & ctl_sync[slave_port_pkg::WR_PIN];                    // [RQ14] [RQ22]

  // ==========================================================================
  // AXI4-Lite write channel holding registers
  logic              aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_held_reg;
  logic [7:0]        w_byte_reg;
  logic              w_lane0_reg;
  logic              wr_fire, wr_en, wr_mapped;
  logic              wr_hit_pin, wr_hit_dir, wr_hit_data, wr_hit_int;

  // Write decode once both address and data are held
  assign wr_fire     = aw_held_reg & w_held_reg & ~bvalid;
  assign wr_en       = wr_fire & w_lane0_reg;
  assign wr_hit_pin  = aw_addr_reg == ADDR_W'(slave_port_pkg::PIN_PORT_ADDR);
  assign wr_hit_dir  = aw_addr_reg == ADDR_W'(slave_port_pkg::DIR_STAT_ADDR);
  assign wr_hit_data = aw_addr_reg == ADDR_W'(slave_port_pkg::DATA_PORT_ADDR);
  assign wr_hit_int  = aw_addr_reg == ADDR_W'(slave_port_pkg::INT_FLAG_ADDR);
  assign wr_mapped   = wr_hit_pin | wr_hit_dir | wr_hit_data | wr_hit_int;

  // Address and data are taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= slave_port_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready     <= 1'b0;
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready      <= 1'b0;
        w_held_reg  <= 1'b1;
        w_byte_reg  <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= wr_mapped ? slave_port_pkg::RESP_OKAY : slave_port_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic       rd_take, cpu_read_data;
  logic       rd_hit_pin, rd_hit_dir, rd_hit_data, rd_hit_int;
  logic [7:0] pin_view, dir_view, int_view, rd_byte;

  assign rd_take     = arvalid & arready;
  assign rd_hit_pin  = araddr == ADDR_W'(slave_port_pkg::PIN_PORT_ADDR);
  assign rd_hit_dir  = araddr == ADDR_W'(slave_port_pkg::DIR_STAT_ADDR);
  assign rd_hit_data = araddr == ADDR_W'(slave_port_pkg::DATA_PORT_ADDR);
  assign rd_hit_int  = araddr == ADDR_W'(slave_port_pkg::INT_FLAG_ADDR);
  assign cpu_read_data = rd_take & rd_hit_data;

  // Read views: pins rather than latch, unused bits zero
  assign pin_view = {5'h00, ctl_sync};                                         // [RQ15] [RQ11]
  assign dir_view = {input_full_reg, output_full_reg, overflow_reg, slave_mode_reg,
                     1'b0, dir_reg};                                           // [RQ4] [RQ5] [RQ8]
  assign int_view = {slave_int_reg, 7'h00};
  assign rd_byte  = rd_hit_pin  ? pin_view :
                    rd_hit_dir  ? dir_view :
                    rd_hit_data ? in_latch_reg :
                    rd_hit_int  ? int_view : 8'h00;

  // One read at a time, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= slave_port_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_byte};
      rresp   <= (rd_hit_pin | rd_hit_dir | rd_hit_data | rd_hit_int) ?
                 slave_port_pkg::RESP_OKAY : slave_port_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Flag and latch next values
  logic input_full_next, output_full_next, overflow_next, slave_int_next;
  logic input_busy, overflow_clear, int_clear, cpu_write_data;

  assign cpu_write_data = wr_en & wr_hit_data;
  assign overflow_clear = wr_en & wr_hit_dir & ~w_byte_reg[slave_port_pkg::OVERFLOW_POS];
  assign int_clear      = wr_en & wr_hit_int & ~w_byte_reg[slave_port_pkg::SLAVE_INT_POS];
  assign input_busy     = input_full_reg & ~cpu_read_data;

  assign input_full_next  = slave_mode_reg & (input_busy | ext_write_done);    // [RQ18] [RQ20]
  assign output_full_next = slave_mode_reg & ((output_full_reg & ~ext_read_done)
                          | cpu_write_data);                                   // [RQ19] [RQ20]
  assign overflow_next    = (overflow_reg & ~overflow_clear)
                          | (ext_write_done & input_busy);                     // [RQ6]
  assign slave_int_next   = (slave_int_reg & ~int_clear)
                          | ext_read_done | ext_write_done;                    // [RQ21]

  // Control state and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg         <= slave_port_pkg::DIR_STAT_RESET[2:0];                  // [RQ10]
      slave_mode_reg  <= slave_port_pkg::DIR_STAT_RESET[slave_port_pkg::SLAVE_MODE_POS];
      input_full_reg  <= slave_port_pkg::DIR_STAT_RESET[slave_port_pkg::INPUT_FULL_POS];
      output_full_reg <= slave_port_pkg::DIR_STAT_RESET[slave_port_pkg::OUTPUT_FULL_POS];
      overflow_reg    <= slave_port_pkg::DIR_STAT_RESET[slave_port_pkg::OVERFLOW_POS];
      slave_int_reg   <= slave_port_pkg::INT_FLAG_RESET[slave_port_pkg::SLAVE_INT_POS];
    end else begin
      if (wr_en && wr_hit_dir) begin
        dir_reg        <= w_byte_reg[2:0];                                     // [RQ9]
        slave_mode_reg <= w_byte_reg[slave_port_pkg::SLAVE_MODE_POS];          // [RQ7]
      end
      input_full_reg  <= input_full_next;
      output_full_reg <= output_full_next;
      overflow_reg    <= overflow_next;
      slave_int_reg   <= slave_int_next;
    end
  end

  // Data latches keep their contents across reset
  always_ff @(posedge aclk) begin
    if (wr_en && wr_hit_pin) begin
      pin_latch_reg <= w_byte_reg[2:0];                                        // [RQ16] [RQ11]
    end
    if (cpu_write_data) begin
      out_latch_reg <= w_byte_reg;
    end
    if (ext_write_done && !input_busy) begin
      in_latch_reg <= data_sync;                                               // [RQ13]
    end
  end

  // ==========================================================================
  // Pin drivers, all straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins.dev_ctl_oe  <= 3'h0;
      pins.dev_ctl_o   <= 3'h0;
      pins.dev_data_oe <= 1'b0;
      pins.dev_data_o  <= 8'h00;
    end else begin
      pins.dev_ctl_oe  <= slave_mode_reg ? 3'h0 : ~dir_reg;                    // [RQ1] [RQ2] [RQ3]
      pins.dev_ctl_o   <= pin_latch_reg;
      pins.dev_data_oe <= slave_mode_reg & ~ctl_sync[slave_port_pkg::SEL_PIN]
                        & ~ctl_sync[slave_port_pkg::RD_PIN];                   // [RQ23] [RQ14]
      pins.dev_data_o  <= out_latch_reg;                                       // [RQ12]
    end
  end

endmodule

// >>> logic/slave_port_master.sv
// External master end: drives select, read and write strobes and the data bus
`timescale 1ns/1ps
module slave_port_master #(
  parameter int STROBE_CYCLES = slave_port_pkg::STROBE_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       drive_en,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  port_pins_if.host       pins
);

  typedef enum logic [2:0] {IDLE, SELECT, STROBE, HOLD, DESELECT} master_state_t;

  master_state_t state_reg;
  logic          write_reg;
  logic [7:0]    count_reg;

  // ==========================================================================
  // Strobe sequencer: select, strobe low, strobe high, deselect, release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= IDLE;
      cmd_ready         <= 1'b1;
      rsp_valid         <= 1'b0;
      rsp_data          <= 8'h00;
      write_reg         <= 1'b0;
      count_reg         <= 8'h00;
      pins.host_ctl_oe  <= 3'h0;
      pins.host_ctl_o   <= 3'h7;
      pins.host_data_oe <= 1'b0;
      pins.host_data_o  <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (cmd_valid && cmd_ready && drive_en) begin                       // [RQ17]
            cmd_ready        <= 1'b0;
            write_reg        <= cmd_write;
            pins.host_data_o <= cmd_data;
            pins.host_ctl_oe <= 3'h7;
            pins.host_ctl_o  <= 3'h7;
            state_reg        <= SELECT;
          end
        end
        SELECT: begin
          pins.host_ctl_o[slave_port_pkg::SEL_PIN] <= 1'b0;                  // [RQ14]
          pins.host_data_oe <= write_reg;
          count_reg         <= 8'(STROBE_CYCLES);
          state_reg         <= STROBE;
        end
        STROBE: begin
          pins.host_ctl_o[slave_port_pkg::RD_PIN] <= write_reg;              // [RQ12]
          pins.host_ctl_o[slave_port_pkg::WR_PIN] <= ~write_reg;             // [RQ13]
          count_reg <= count_reg - 8'h01;
          if (count_reg == 8'h01) begin
            rsp_data  <= write_reg ? rsp_data : pins.data_level;
            state_reg <= HOLD;
          end
        end
        HOLD: begin
          pins.host_ctl_o[slave_port_pkg::RD_PIN] <= 1'b1;
          pins.host_ctl_o[slave_port_pkg::WR_PIN] <= 1'b1;
          state_reg <= DESELECT;
        end
        DESELECT: begin
          pins.host_ctl_o[slave_port_pkg::SEL_PIN] <= 1'b1;
          pins.host_data_oe <= 1'b0;
          rsp_valid         <= 1'b1;
          state_reg         <= IDLE;
          cmd_ready         <= 1'b1;
          pins.host_ctl_oe  <= 3'h0;
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end

endmodule

// >>> logic/slave_port_pkg.sv
// Shared constants for the control-pin port and its parallel slave port
package slave_port_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times the index)
  localparam logic [7:0]  DATA_PORT_IDX = 8'h08;
  localparam logic [7:0]  PIN_PORT_IDX  = 8'h09;
  localparam logic [7:0]  INT_FLAG_IDX  = 8'h0c;
  localparam logic [7:0]  DIR_STAT_IDX  = 8'h89;
  localparam logic [11:0] DATA_PORT_ADDR = {2'b00, DATA_PORT_IDX, 2'b00};
  localparam logic [11:0] PIN_PORT_ADDR  = {2'b00, PIN_PORT_IDX, 2'b00};
  localparam logic [11:0] INT_FLAG_ADDR  = {2'b00, INT_FLAG_IDX, 2'b00};
  localparam logic [11:0] DIR_STAT_ADDR  = {2'b00, DIR_STAT_IDX, 2'b00};

  // ==========================================================================
  // Field positions of the direction/status register
  localparam int INPUT_FULL_POS  = 7;
  localparam int OUTPUT_FULL_POS = 6;
  localparam int OVERFLOW_POS    = 5;
  localparam int SLAVE_MODE_POS  = 4;
  // Field position of the slave-port event flag in the interrupt flag register
  localparam int SLAVE_INT_POS   = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] DIR_STAT_RESET = 8'h07;
  localparam logic [7:0] INT_FLAG_RESET = 8'h00;

  // ==========================================================================
  // Control pin positions and bus answers
  localparam int RD_PIN  = 0;
  localparam int WR_PIN  = 1;
  localparam int SEL_PIN = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing counts in aclk cycles
  localparam int STROBE_CYCLES = 6;

endpackage

// >>> verif/slave_port_props.sv
// Pin-level checker for the device and master ends of the parallel slave port
`timescale 1ns/1ps
module slave_port_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [2:0] dev_ctl_o,
  input wire logic [2:0] dev_ctl_oe,
  input wire logic [2:0] host_ctl_o,
  input wire logic [2:0] host_ctl_oe,
  input wire logic [7:0] dev_data_o,
  input wire logic       dev_data_oe,
  input wire logic [7:0] host_data_o,
  input wire logic       host_data_oe,
  input wire logic [2:0] ctl_level,
  input wire logic [7:0] data_level
);
  // ==========================================================================
  // One clock domain for every property
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Pin ownership: no two drivers on one wire
  data_contention_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data pins");
  ctl_contention_a: assert property ((dev_ctl_oe & host_ctl_oe) == 3'h0)
    else $error("both ends drive a control pin");
  mode_pins_input_a: assert property (dev_data_oe |-> dev_ctl_oe == 3'h0)
    else $error("control pins driven while slave port answers");

  // ==========================================================================
  // Read answers only while selected and reading, released after strobe ends
  read_drive_start_a: assert property ($rose(dev_data_oe) |-> !ctl_level[0] && !ctl_level[2])
    else $error("data pins driven without select and read strobe");
  read_release_a: assert property ($rose(ctl_level[0]) |-> ##[1:5] !dev_data_oe)
    else $error("data pins not released after read strobe");

  // ==========================================================================
  // Strobe framing by the master end
  read_strobe_len_a: assert property ($fell(ctl_level[0]) && host_ctl_oe[0]
    |=> !ctl_level[0] [*5] ##1 ctl_level[0])
    else $error("read strobe width wrong");
  write_strobe_len_a: assert property ($fell(ctl_level[1]) && host_ctl_oe[1]
    |=> !ctl_level[1] [*5] ##1 ctl_level[1])
    else $error("write strobe width wrong");
  select_frames_a: assert property (host_ctl_oe[2] && ctl_level[1:0] != 2'h3 |-> !ctl_level[2])
    else $error("strobe low without select");
  write_data_held_a: assert property (host_ctl_oe[1] && !ctl_level[1]
    |-> host_data_oe && $stable(host_data_o))
    else $error("write data not held under strobe");

  // ==========================================================================
  // Main scenarios reached
  read_seen_c: cover property ($rose(dev_data_oe));
  write_seen_c: cover property ($fell(ctl_level[1]) && host_ctl_oe[1]);
  gpio_drive_c: cover property (dev_ctl_oe != 3'h0);
endmodule

// >>> verif/tb.sv
// Self-checking bench for the control-pin port, its registers and the slave port
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, cmd_ready, rsp_valid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata;
  logic        drive_en = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [7:0]  cmd_data = 8'h00, rsp_data, rd;
  int          errors = 0;
  int          samples_checked = 0;

  // ==========================================================================
  // Clock, design ends and checker
  always #12.5 aclk = ~aclk;
  port_pins_if u_port_pins_if ();
  slave_port_device u_slave_port_device (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pins(u_port_pins_if.device));
  slave_port_master u_slave_port_master (.aclk(aclk), .aresetn(aresetn), .drive_en(drive_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(u_port_pins_if.host));
  slave_port_props u_slave_port_props (.aclk(aclk), .aresetn(aresetn),
    .dev_ctl_o(u_port_pins_if.dev_ctl_o), .dev_ctl_oe(u_port_pins_if.dev_ctl_oe),
    .host_ctl_o(u_port_pins_if.host_ctl_o), .host_ctl_oe(u_port_pins_if.host_ctl_oe),
    .dev_data_o(u_port_pins_if.dev_data_o), .dev_data_oe(u_port_pins_if.dev_data_oe),
    .host_data_o(u_port_pins_if.host_data_o), .host_data_oe(u_port_pins_if.host_data_oe),
    .ctl_level(u_port_pins_if.ctl_level), .data_level(u_port_pins_if.data_level));

  // ==========================================================================
  // Comparison and closing
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register bus cycles: hold each channel until taken, wait for the answer
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic reg_check(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    axi_read(a, d);
    check_byte(what, exp, d);
  endtask

  // External master transfer, then let the synchronised strobe edge land
  task automatic ext_xfer(input logic w, input logic [7:0] d);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_data  <= d;
    do @(posedge aclk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    do @(posedge aclk); while (!rsp_valid);
    repeat (6) @(posedge aclk);
  endtask

  // ==========================================================================
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    $display("unexpected timeout: expected finish, seen hang");
    tally_and_finish();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    reg_check("dir_status reset", slave_port_pkg::DIR_STAT_ADDR, 8'h07);
    reg_check("int flags reset", slave_port_pkg::INT_FLAG_ADDR, 8'h00);
    reg_check("unmapped data", 12'h100, 8'h00);
    check_resp("unmapped resp", slave_port_pkg::RESP_SLVERR, resp);
    $display("test reset_values done");
    // General-purpose pins: per-pin direction, pin reads and bit operations
    axi_write(slave_port_pkg::PIN_PORT_ADDR, 8'h04);
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h0a);
    check_resp("dir write resp", slave_port_pkg::RESP_OKAY, resp);
    reg_check("dir_status bit3", slave_port_pkg::DIR_STAT_ADDR, 8'h02);
    repeat (6) @(posedge aclk);
    check_byte("pin levels", 8'h06, {5'h00, u_port_pins_if.ctl_level});
    axi_read(slave_port_pkg::PIN_PORT_ADDR, rd);
    check_byte("pin port read", 8'h06, rd);
    axi_write(slave_port_pkg::PIN_PORT_ADDR, rd | 8'h01);
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h00);
    repeat (6) @(posedge aclk);
    reg_check("bit op rewrite", slave_port_pkg::PIN_PORT_ADDR, 8'h07);
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h07);
    $display("test gpio done");
    // Slave mode: CPU word read by the master
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h17);
    repeat (3) @(posedge aclk);
    check_byte("ctl drive in mode", 8'h00, {5'h00, u_port_pins_if.dev_ctl_oe});
    drive_en <= 1'b1;
    axi_write(slave_port_pkg::DATA_PORT_ADDR, 8'h5a);
    reg_check("out full set", slave_port_pkg::DIR_STAT_ADDR, 8'h57);
    ext_xfer(1'b0, 8'h00);
    check_byte("master read", 8'h5a, rsp_data);
    reg_check("out full clear", slave_port_pkg::DIR_STAT_ADDR, 8'h17);
    reg_check("event flag", slave_port_pkg::INT_FLAG_ADDR, 8'h80);
    axi_write(slave_port_pkg::INT_FLAG_ADDR, 8'h00);
    reg_check("event clear", slave_port_pkg::INT_FLAG_ADDR, 8'h00);
    $display("test slave_read done");
    // Slave mode: two master writes, overflow keeps the first word
    ext_xfer(1'b1, 8'ha5);
    reg_check("in full set", slave_port_pkg::DIR_STAT_ADDR, 8'h97);
    ext_xfer(1'b1, 8'h3c);
    reg_check("overflow set", slave_port_pkg::DIR_STAT_ADDR, 8'hb7);
    reg_check("first word kept", slave_port_pkg::DATA_PORT_ADDR, 8'ha5);
    reg_check("in full clear", slave_port_pkg::DIR_STAT_ADDR, 8'h37);
    axi_write(slave_port_pkg::DATA_PORT_ADDR, 8'h11);
    drive_en <= 1'b0;
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h27);
    reg_check("mode off flags", slave_port_pkg::DIR_STAT_ADDR, 8'h27);
    axi_write(slave_port_pkg::DIR_STAT_ADDR, 8'h07);
    reg_check("overflow cleared", slave_port_pkg::DIR_STAT_ADDR, 8'h07);
    $display("test slave_write done");
    tally_and_finish();
  end
endmodule
